// [crd_top.sv]
// commanded reboot delay controller: two-wire target, reboot register and wait sequencer
`timescale 1ns/1ns
`default_nettype none

module crd_top #(
  parameter int unsigned WAIT_BASE_CYCLES = crd_pkg::REBOOT_WAIT_MIN_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic link_clk,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  output logic      power_en,
  output logic      wait_pending
);

  // crossings between the link and system domains
  logic [3:0] lsync;
  logic [1:0] ssync;
  logic       wr_tgl_reg;
  logic       rd_req_tgl_reg;
  logic       rd_ack_tgl_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wr_data_reg;

  // pins, reset and the read answer toggle into the link domain
  crd_sync #(
    .WIDTH (4)
  ) u_link_sync (
    .clk      (link_clk),
    .async_in ({rst_n, scl, sda_in, rd_ack_tgl_reg}),
    .sync_out (lsync)
  );

  // write and read request toggles into the system domain
  crd_sync #(
    .WIDTH (2)
  ) u_sys_sync (
    .clk      (sys_clk),
    .async_in ({wr_tgl_reg, rd_req_tgl_reg}),
    .sync_out (ssync)
  );

  logic link_rst_n;
  logic scl_s;
  logic sda_s;
  logic ack_s;

  assign link_rst_n = lsync[3];
  assign scl_s      = lsync[2];
  assign sda_s      = lsync[1];
  assign ack_s      = lsync[0];

  // link domain: two-wire bus target
  crd_pkg::crd_link_state_type lstate_reg;
  crd_pkg::crd_link_state_type lstate_next;
  crd_pkg::crd_phase_type      phase_reg;
  crd_pkg::crd_phase_type      phase_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] ptr_next;
  logic [7:0] wr_data_next;
  logic [7:0] rd_byte_reg;
  logic [7:0] rd_byte_next;
  logic       wr_tgl_next;
  logic       rd_req_tgl_next;
  logic       ack_seen_reg;
  logic       ack_seen_next;
  logic       read_reg;
  logic       read_next;
  logic       mack_reg;
  logic       mack_next;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       sda_oe_n_reg;
  logic       sda_oe_n_next;
  logic       sda_out_reg;

  logic       bus_start;
  logic       bus_stop;
  logic       scl_rise;
  logic       scl_fall;

  // bus conditions seen on the synchronised pins
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;

  // target state machine; sda changes only after scl falls
  always_comb begin
    lstate_next     = lstate_reg;
    phase_next      = phase_reg;
    bit_cnt_next    = bit_cnt_reg;
    sh_next         = sh_reg;
    tx_next         = tx_reg;
    ptr_next        = ptr_reg;
    wr_data_next    = wr_data_reg;
    rd_byte_next    = rd_byte_reg;
    wr_tgl_next     = wr_tgl_reg;
    rd_req_tgl_next = rd_req_tgl_reg;
    ack_seen_next   = ack_seen_reg;
    read_next       = read_reg;
    mack_next       = mack_reg;
    sda_oe_n_next   = sda_oe_n_reg;
    // read answer: data is held stable by the system side until the next request
    if (ack_s != ack_seen_reg) begin
      ack_seen_next = ack_s;
      rd_byte_next  = rd_data_reg;
    end
    if (bus_start) begin
      lstate_next   = crd_pkg::L_RX;
      phase_next    = crd_pkg::PH_ADDR;
      bit_cnt_next  = 4'h0;
      sda_oe_n_next = 1'b1;
    end else if (bus_stop) begin
      lstate_next   = crd_pkg::L_IDLE;
      sda_oe_n_next = 1'b1;
    end else begin
      case (lstate_reg)
        crd_pkg::L_IDLE: begin
          sda_oe_n_next = 1'b1;
        end
        crd_pkg::L_RX: begin
          if (scl_rise) begin
            sh_next      = {sh_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == crd_pkg::BYTE_BITS) begin
            sda_oe_n_next = 1'b0;
            lstate_next   = crd_pkg::L_ACK;
            case (phase_reg)
              crd_pkg::PH_ADDR: begin
                if (sh_reg[7:1] == crd_pkg::DEV_ADDR) begin
                  read_next = sh_reg[0];
                  if (sh_reg[0]) begin
                    rd_req_tgl_next = ~rd_req_tgl_reg;
                  end
                end else begin
                  // another target's address: stay off the bus
                  sda_oe_n_next = 1'b1;
                  lstate_next   = crd_pkg::L_IDLE;
                end
              end
              crd_pkg::PH_PTR: begin
                ptr_next = sh_reg;
              end
              default: begin
                // unmapped writes are acknowledged and dropped
                if (ptr_reg == crd_pkg::REG_REBOOT_CTRL) begin
                  wr_data_next = sh_reg;
                  wr_tgl_next  = ~wr_tgl_reg;
                end
              end
            endcase
          end
        end
        crd_pkg::L_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (read_reg) begin
              lstate_next   = crd_pkg::L_TX;
              tx_next       = rd_byte_reg;
              sda_oe_n_next = rd_byte_reg[7];
            end else begin
              lstate_next   = crd_pkg::L_RX;
              sda_oe_n_next = 1'b1;
              phase_next    = (phase_reg == crd_pkg::PH_ADDR) ? crd_pkg::PH_PTR : crd_pkg::PH_DATA;
            end
          end
        end
        crd_pkg::L_TX: begin
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == crd_pkg::BYTE_BITS) begin
              sda_oe_n_next = 1'b1;
              lstate_next   = crd_pkg::L_TXACK;
            end else begin
              tx_next       = {tx_reg[6:0], 1'b0};
              sda_oe_n_next = tx_reg[6];
            end
          end
        end
        crd_pkg::L_TXACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (mack_reg) begin
              // no auto-increment: the same register is sent again
              lstate_next   = crd_pkg::L_TX;
              tx_next       = rd_byte_reg;
              sda_oe_n_next = rd_byte_reg[7];
            end else begin
              lstate_next = crd_pkg::L_IDLE;
            end
          end
        end
        default: begin
          lstate_next   = crd_pkg::L_IDLE;
          sda_oe_n_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lstate_reg     <= crd_pkg::L_IDLE;
      phase_reg      <= crd_pkg::PH_ADDR;
      bit_cnt_reg    <= 4'h0;
      sh_reg         <= 8'h00;
      tx_reg         <= 8'h00;
      ptr_reg        <= 8'h00;
      wr_data_reg    <= 8'h00;
      rd_byte_reg    <= 8'h00;
      wr_tgl_reg     <= 1'b0;
      rd_req_tgl_reg <= 1'b0;
      ack_seen_reg   <= 1'b0;
      read_reg       <= 1'b0;
      mack_reg       <= 1'b0;
      scl_d_reg      <= 1'b1;
      sda_d_reg      <= 1'b1;
      sda_oe_n_reg   <= 1'b1;
      sda_out_reg    <= 1'b0;
    end else begin
      lstate_reg     <= lstate_next;
      phase_reg      <= phase_next;
      bit_cnt_reg    <= bit_cnt_next;
      sh_reg         <= sh_next;
      tx_reg         <= tx_next;
      ptr_reg        <= ptr_next;
      wr_data_reg    <= wr_data_next;
      rd_byte_reg    <= rd_byte_next;
      wr_tgl_reg     <= wr_tgl_next;
      rd_req_tgl_reg <= rd_req_tgl_next;
      ack_seen_reg   <= ack_seen_next;
      read_reg       <= read_next;
      mack_reg       <= mack_next;
      scl_d_reg      <= scl_s;
      sda_d_reg      <= sda_s;
      sda_oe_n_reg   <= sda_oe_n_next;
      sda_out_reg    <= 1'b0;  // open drain: only ever pulls low
    end
  end

  // system domain: reboot register and wait sequencer
  crd_pkg::crd_sys_state_type sstate_reg;
  crd_pkg::crd_sys_state_type sstate_next;
  logic        req_reg;
  logic        req_next;
  logic [2:0]  sel_reg;
  logic [2:0]  sel_next;
  logic [31:0] wait_cnt_reg;
  logic [31:0] wait_cnt_next;
  logic        power_en_reg;
  logic        power_en_next;
  logic        pending_reg;
  logic        pending_next;
  logic        load_start_reg;
  logic        load_start_next;
  logic [7:0]  rd_data_next;
  logic        rd_ack_tgl_next;
  logic        wr_seen_reg;
  logic        wr_seen_next;
  logic        rq_seen_reg;
  logic        rq_seen_next;
  logic [7:0]  reg_value;
  logic [2:0]  wr_sel;
  logic        nvm_done;
  logic [2:0]  nvm_sel;

  crd_nvm_loader u_nvm (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .load_start        (load_start_reg),
    .load_done         (nvm_done),
    .wait_select_image (nvm_sel)
  );

  assign wr_sel = wr_data_reg[crd_pkg::SEL_LSB +: crd_pkg::SEL_WIDTH];

  // register image; reserved bits read as zero
  always_comb begin
    reg_value                                            = crd_pkg::REBOOT_CTRL_RESET;
    reg_value[crd_pkg::REQ_BIT]                          = req_reg;
    reg_value[crd_pkg::PEND_BIT]                         = pending_reg;
    reg_value[crd_pkg::SEL_LSB +: crd_pkg::SEL_WIDTH]    = sel_reg;
  end

  // write data and pointer are stable while their toggle is in flight
  always_comb begin
    sstate_next     = sstate_reg;
    req_next        = req_reg;
    sel_next        = sel_reg;
    wait_cnt_next   = wait_cnt_reg;
    power_en_next   = power_en_reg;
    pending_next    = pending_reg;
    load_start_next = 1'b0;
    rd_data_next    = rd_data_reg;
    rd_ack_tgl_next = rd_ack_tgl_reg;
    wr_seen_next    = ssync[1];
    rq_seen_next    = ssync[0];
    if (ssync[0] != rq_seen_reg) begin
      rd_data_next    = (ptr_reg == crd_pkg::REG_REBOOT_CTRL) ? reg_value : crd_pkg::UNMAPPED_READ;
      rd_ack_tgl_next = ~rd_ack_tgl_reg;
    end
    if (ssync[1] != wr_seen_reg) begin
      req_next = wr_data_reg[crd_pkg::REQ_BIT];
      sel_next = wr_sel;
      // only a 0 to 1 change of the request bit starts a reboot
      if (wr_data_reg[crd_pkg::REQ_BIT] && !req_reg && sstate_reg == crd_pkg::S_RUN) begin
        sstate_next   = crd_pkg::S_WAIT;
        power_en_next = 1'b0;
        pending_next  = 1'b1;
        wait_cnt_next = (32'(WAIT_BASE_CYCLES) << wr_sel) - 32'h1;
      end
    end
    case (sstate_reg)
      crd_pkg::S_RELOAD: begin
        power_en_next = 1'b0;
        if (nvm_done) begin
          // reload leaves the request bit as it is
          sel_next      = nvm_sel;
          sstate_next   = crd_pkg::S_RUN;
          power_en_next = 1'b1;
        end
      end
      crd_pkg::S_RUN: begin
      end
      crd_pkg::S_WAIT: begin
        // a longer select written mid-wait does not stretch this wait
        if (wait_cnt_reg == 32'h0) begin
          pending_next    = 1'b0;
          sstate_next     = crd_pkg::S_RELOAD;
          load_start_next = 1'b1;
        end else begin
          wait_cnt_next = wait_cnt_reg - 32'h1;
        end
      end
      default: begin
        sstate_next     = crd_pkg::S_RELOAD;
        load_start_next = 1'b1;
      end
    endcase
  end

  // reset behaves like power-up: reload first, power stays off meanwhile
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sstate_reg     <= crd_pkg::S_RELOAD;
      req_reg        <= crd_pkg::REBOOT_CTRL_RESET[crd_pkg::REQ_BIT];
      sel_reg        <= crd_pkg::REBOOT_CTRL_RESET[crd_pkg::SEL_LSB +: crd_pkg::SEL_WIDTH];
      wait_cnt_reg   <= 32'h0;
      power_en_reg   <= 1'b0;
      pending_reg    <= 1'b0;
      load_start_reg <= 1'b1;
      rd_data_reg    <= 8'h00;
      rd_ack_tgl_reg <= 1'b0;
      wr_seen_reg    <= 1'b0;
      rq_seen_reg    <= 1'b0;
    end else begin
      sstate_reg     <= sstate_next;
      req_reg        <= req_next;
      sel_reg        <= sel_next;
      wait_cnt_reg   <= wait_cnt_next;
      power_en_reg   <= power_en_next;
      pending_reg    <= pending_next;
      load_start_reg <= load_start_next;
      rd_data_reg    <= rd_data_next;
      rd_ack_tgl_reg <= rd_ack_tgl_next;
      wr_seen_reg    <= wr_seen_next;
      rq_seen_reg    <= rq_seen_next;
    end
  end

  // outputs straight from flops
  assign sda_out      = sda_out_reg;
  assign sda_oe_n     = sda_oe_n_reg;
  assign power_en     = power_en_reg;
  assign wait_pending = pending_reg;

endmodule : crd_top

`default_nettype wire

// [crd_pkg.sv]
// constants and state types for the commanded reboot delay controller
// Function
// - setting the reboot request bit at register 0xA2 turns the output power path off, starts a timed wait, then restarts.
// - a three-bit wait select field in the reboot control register picks the wait, from 512 ms up to 65.5 s.
// - the delay pending flag reads 1 for the whole wait and drops to 0 when the wait runs out.
// - at the end of a commanded reboot the volatile configuration is reloaded from nonvolatile memory as at power-up.
// - the reboot request bit stays 1 after the reboot; neither the device nor the reload clears it.
`default_nettype none

package crd_pkg;

  // register map and field layout
  localparam logic [7:0]  REG_REBOOT_CTRL   = 8'hA2;
  localparam int unsigned REQ_BIT           = 7;
  localparam int unsigned PEND_BIT          = 6;
  localparam int unsigned SEL_LSB           = 0;
  localparam int unsigned SEL_WIDTH         = 3;
  localparam logic [7:0]  REBOOT_CTRL_RESET = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

  // two-wire bus target address and byte length
  localparam logic [6:0]  DEV_ADDR          = 7'h10;
  localparam logic [3:0]  BYTE_BITS         = 4'h8;

  // timing
  localparam int unsigned SYS_CLK_HZ          = 25_000_000;
  localparam int unsigned REBOOT_WAIT_MIN_MS  = 512;
  localparam int unsigned REBOOT_WAIT_MIN_CYC = REBOOT_WAIT_MIN_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned NVM_READ_CYC        = 16;

  // nonvolatile image of the wait select field
  localparam logic [2:0]  NVM_WAIT_SELECT   = 3'h0;

  typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_TX, L_TXACK} crd_link_state_type;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} crd_phase_type;
  typedef enum logic [1:0] {S_RELOAD, S_RUN, S_WAIT} crd_sys_state_type;

endpackage : crd_pkg

`default_nettype wire

// [crd_sync.sv]
// two-flop synchroniser, one chain per bit
`timescale 1ns/1ns
`default_nettype none

module crd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output wire logic [WIDTH-1:0] sync_out
);

  // first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic stage1_reg;
    logic stage2_reg;
    always_ff @(posedge clk) begin
      stage1_reg <= async_in[i];
      stage2_reg <= stage1_reg;
    end
    assign sync_out[i] = stage2_reg;
  end

endmodule : crd_sync

`default_nettype wire

// [crd_nvm_loader.sv]
// nonvolatile configuration reload sequencer
`timescale 1ns/1ns
`default_nettype none

module crd_nvm_loader (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       load_start,
  output logic            load_done,
  output logic      [2:0] wait_select_image
);

  logic       busy_reg;
  logic       busy_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic       done_reg;
  logic       done_next;

  // models the array read latency before the stored word is valid
  always_comb begin
    busy_next = busy_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (load_start) begin
      busy_next = 1'b1;
      cnt_next  = 5'(crd_pkg::NVM_READ_CYC - 1);
    end else if (busy_reg) begin
      if (cnt_reg == 5'h00) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 5'h00;
      done_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign load_done         = done_reg;
  assign wait_select_image = crd_pkg::NVM_WAIT_SELECT;

endmodule : crd_nvm_loader

`default_nettype wire

// [crd_top_properties.sv]
// concurrent checks on the reboot controller ports
`timescale 1ns/1ns
`default_nettype none

module crd_top_properties #(
  parameter int unsigned WAIT_BASE_CYCLES = crd_pkg::REBOOT_WAIT_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic power_en,
  input wire logic wait_pending
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic [31:0] wait_cnt_reg;
  logic [31:0] wait_cnt_next;

  // length of the current wait, zeroed between waits
  always_comb begin
    wait_cnt_next = wait_pending ? wait_cnt_reg + 32'h1 : 32'h0;
  end

  always_ff @(posedge sys_clk) begin
    wait_cnt_reg <= rst_n ? wait_cnt_next : 32'h0;
  end

  // only the eight doubling steps of the base wait are legal
  function automatic logic width_ok(input logic [31:0] c);
    logic ok;
    ok = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (c == (WAIT_BASE_CYCLES << k)) ok = 1'b1;
    end
    return ok;
  endfunction : width_ok

  // power stays off through the reload, then comes back in a short window
  sequence s_reload_off;
    (!power_en && !wait_pending)[*8];
  endsequence
  sequence s_restart;
    (!power_en)[*8] ##[8:14] power_en;
  endsequence

  chk_reset_reload: assert property ($rose(rst_n) |-> s_reload_off ##[6:14] power_en)
    else $error("power-up reload timing wrong");
  chk_wait_start: assert property ($rose(wait_pending) |-> $fell(power_en))
    else $error("wait began without power turning off");
  chk_off_cause: assert property ($fell(power_en) |-> wait_pending)
    else $error("power dropped without a wait");
  chk_power_off: assert property (wait_pending |-> !power_en)
    else $error("power on during wait");
  chk_restart_win: assert property ($fell(wait_pending) |-> s_restart)
    else $error("restart not within window after wait");
  chk_wait_width: assert property ($fell(wait_pending) |-> width_ok(wait_cnt_reg))
    else $error("wait length is not a legal step");
  chk_wait_max: assert property (wait_cnt_reg <= (WAIT_BASE_CYCLES << 7))
    else $error("wait longer than the longest step");
  chk_sda_open: assert property (sda_out == 1'b0)
    else $error("data pin driven high");

endmodule : crd_top_properties

`default_nettype wire

// [crd_host_model.sv]
// two-wire bus master that issues register commands
`timescale 1ns/1ns
`default_nettype none

module crd_host_model #(
  parameter int HALF_NS = 1250
) (
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_drv
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // start and repeated start: sda falls while scl is high
  task automatic bus_start();
    sda_drv = 1'b1;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda_drv = 1'b0;
    #HALF_NS scl = 1'b0;
    #HALF_NS;
  endtask : bus_start

  task automatic bus_stop();
    sda_drv = 1'b0;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda_drv = 1'b1;
    #HALF_NS;
  endtask : bus_stop

  // data changes only while scl is low; ack sampled at end of high
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      #HALF_NS scl = 1'b1;
      #HALF_NS scl = 1'b0;
    end
    sda_drv = 1'b1;
    #HALF_NS scl = 1'b1;
    #HALF_NS ack = (sda === 1'b0);
    scl = 1'b0;
  endtask : send_byte

  task automatic recv_byte(input logic nack, output logic [7:0] b);
    sda_drv = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #HALF_NS scl = 1'b1;
      #HALF_NS b[i] = sda;
      scl = 1'b0;
    end
    sda_drv = nack;
    #HALF_NS scl = 1'b1;
    #HALF_NS scl = 1'b0;
  endtask : recv_byte

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr, input logic [7:0] data,
                           output logic [2:0] acks);
    bus_start();
    send_byte({addr, 1'b0}, acks[2]);
    send_byte(ptr, acks[1]);
    send_byte(data, acks[0]);
    bus_stop();
  endtask : write_reg

  // pointer write, repeated start, one byte read, nack
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic [2:0] acks);
    bus_start();
    send_byte({crd_pkg::DEV_ADDR, 1'b0}, acks[2]);
    send_byte(ptr, acks[1]);
    bus_start();
    send_byte({crd_pkg::DEV_ADDR, 1'b1}, acks[0]);
    recv_byte(1'b1, data);
    bus_stop();
  endtask : read_reg

endmodule : crd_host_model

`default_nettype wire

// [test_crd_top.sv]
// self-checking bench for the commanded reboot delay controller
`timescale 1ns/1ns
`default_nettype none

module test_crd_top;
  localparam int unsigned BASE = 20;

  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl;
  logic        sda_drv;
  wire logic   sda;
  logic        sda_out;
  logic        sda_oe_n;
  logic        power_en;
  logic        wait_pending;
  logic [7:0]  rd;
  logic [2:0]  acks;
  logic [31:0] run_cnt = 32'h0;
  logic [31:0] last_width = 32'h0;
  logic [31:0] reboots = 32'h0;
  int          fails = 0;
  int          comparisons = 0;

  always #20 sys_clk = ~sys_clk;
  always #6 link_clk = ~link_clk;

  // open-drain line with pull-up: low if either side pulls, target shows its drive value when enabled
  assign sda = sda_drv & (sda_oe_n | sda_out);

  crd_top #(.WAIT_BASE_CYCLES(BASE)) dut_u (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .link_clk     (link_clk),
    .scl          (scl),
    .sda_in       (sda),
    .sda_out      (sda_out),
    .sda_oe_n     (sda_oe_n),
    .power_en     (power_en),
    .wait_pending (wait_pending)
  );

  crd_host_model host_u (
    .sda     (sda),
    .scl     (scl),
    .sda_drv (sda_drv)
  );

  // wait length and start count measured away from the launching edge
  always @(negedge sys_clk) begin
    if (wait_pending === 1'b1) begin
      if (run_cnt == 32'h0) reboots = reboots + 32'h1;
      run_cnt = run_cnt + 32'h1;
    end else if (run_cnt != 32'h0) begin
      last_width = run_cnt;
      run_cnt = 32'h0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    comparisons++;
    if (seen !== expected) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // bounded wait for power to come back; the longest wait plus reload margin
  task automatic wait_power_on();
    int n;
    n = 0;
    while (power_en !== 1'b1 && n < (BASE << 7) + 200) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    check({31'h0, power_en}, 32'h1);
    repeat (4) @(posedge sys_clk);
  endtask : wait_power_on

  initial begin
    #4_000_000;
    fails++;
    end_sim();
  end

  initial begin
    repeat (7) @(posedge sys_clk);
    #2 check({30'h0, power_en, wait_pending}, 32'h0);
    @(posedge sys_clk);
    #2 rst_n = 1'b1;
    wait_power_on();
    host_u.read_reg(crd_pkg::REG_REBOOT_CTRL, rd, acks);
    check({21'h0, acks, rd}, {21'h0, 3'h7, crd_pkg::REBOOT_CTRL_RESET});
    // select alone is stored without starting a reboot
    host_u.write_reg(crd_pkg::DEV_ADDR, crd_pkg::REG_REBOOT_CTRL, 8'h05, acks);
    host_u.read_reg(crd_pkg::REG_REBOOT_CTRL, rd, acks);
    check({24'h0, rd}, 32'h5);
    // wrong target address is never acknowledged and changes nothing
    host_u.write_reg(crd_pkg::DEV_ADDR ^ 7'h01, crd_pkg::REG_REBOOT_CTRL, 8'h80, acks);
    check({29'h0, acks}, 32'h0);
    // other pointers: write dropped, read gives the unmapped value
    host_u.write_reg(crd_pkg::DEV_ADDR, 8'h10, 8'hFF, acks);
    host_u.read_reg(8'h10, rd, acks);
    check({24'h0, rd}, {24'h0, crd_pkg::UNMAPPED_READ});
    check(reboots, 32'h0);
    // every wait select step, each followed by the host clearing the request
    for (int n = 0; n < 8; n++) begin
      host_u.write_reg(crd_pkg::DEV_ADDR, crd_pkg::REG_REBOOT_CTRL, 8'h80 | 8'(n), acks);
      check({29'h0, acks}, 32'h7);
      if (n == 7) begin
        // power is looked at right after the write; the read below outlasts the wait
        check({31'h0, power_en}, 32'h0);
        check({31'h0, wait_pending}, 32'h1);
        host_u.read_reg(crd_pkg::REG_REBOOT_CTRL, rd, acks);
        check({24'h0, rd}, 32'hC7);
      end
      wait_power_on();
      check(last_width, BASE << n);
      check({31'h0, wait_pending}, 32'h0);
      check(reboots, 32'(n + 1));
      host_u.read_reg(crd_pkg::REG_REBOOT_CTRL, rd, acks);
      check({24'h0, rd}, 32'h80);
      if (n == 0) begin
        // a second 1 without clearing first is not a new command
        host_u.write_reg(crd_pkg::DEV_ADDR, crd_pkg::REG_REBOOT_CTRL, 8'h81, acks);
        repeat (300) @(posedge sys_clk);
        check(reboots, 32'h1);
      end
      host_u.write_reg(crd_pkg::DEV_ADDR, crd_pkg::REG_REBOOT_CTRL, 8'h00, acks);
    end
    end_sim();
  end

endmodule : test_crd_top

bind crd_top crd_top_properties #(.WAIT_BASE_CYCLES(WAIT_BASE_CYCLES)) chk_u (
  .sys_clk      (sys_clk),
  .rst_n        (rst_n),
  .link_clk     (link_clk),
  .scl          (scl),
  .sda_in       (sda_in),
  .sda_out      (sda_out),
  .sda_oe_n     (sda_oe_n),
  .power_en     (power_en),
  .wait_pending (wait_pending)
);

`default_nettype wire
